/* File: low_power_timer_pkg.sv */
// constants, field layout and state types of the low-power timer
// assumes one 50 MHz clock and a 32-bit APB register port
package low_power_timer_pkg;
	// register byte offsets
	localparam logic [11:0] CFG_OFFSET = 12'h000;
	localparam logic [11:0] CTRL_OFFSET = 12'h004;
	localparam logic [11:0] RELOAD_OFFSET = 12'h008;
	localparam logic [11:0] COUNT_OFFSET = 12'h00C;
	localparam logic [11:0] STATUS_OFFSET = 12'h010;
	// configuration field positions
	localparam int CLK_SEL_POS = 0;
	localparam int CLK_EDGE_POS = 1;
	localparam int IN_FILT_POS = 3;
	localparam int TRIG_FILT_POS = 5;
	localparam int PRESCALE_POS = 7;
	localparam int TRIG_SEL_POS = 10;
	localparam int TRIG_EN_POS = 13;
	localparam int WAVE_POS = 15;
	localparam int EXT_COUNT_POS = 16;
	localparam int SOURCE_POS = 17;
	localparam int CFG_WIDTH = 20;
	// control bit positions
	localparam int ENABLE_POS = 0;
	localparam int SINGLE_POS = 1;
	localparam int CONT_POS = 2;
	// reset values
	localparam logic [19:0] CFG_RESET = 20'h0_0000;
	localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
	// counter clock periods between enable and kernel on
	localparam logic [1:0] ENABLE_DELAY = 2'h2;
	// edge field codes
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] TRIG_SOFT = 2'h0;
	localparam logic [1:0] TRIG_RISE = 2'h1;
	localparam logic [1:0] TRIG_FALL = 2'h2;

	typedef enum logic [1:0] {ST_OFF, ST_WARMUP, ST_STOPPED, ST_RUNNING}
		run_state_type;
endpackage : low_power_timer_pkg

/* File: low_power_timer.sv */
// low-power timer: apb registers, count clock select, filters, triggers
// assumes all tick and pin inputs are synchronous to sys_clk
`timescale 1ns/100ps
module low_power_timer
	import low_power_timer_pkg::*;
#(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lsi_tick,
	input wire logic lse_tick,
	input wire logic hsi_tick,
	input wire logic hse_tick,
	input wire logic comparator_tick,
	input wire logic external_input_one,
	input wire logic trigger_pin,
	input wire logic alarm_a,
	input wire logic alarm_b,
	input wire logic tamper_event_one,
	input wire logic tamper_event_two,
	input wire logic comparator_out,
	output logic counter_running,
	output logic [COUNT_WIDTH-1:0] count_value
);
	logic [CFG_WIDTH-1:0] cfg;
	logic timer_enable_bit;
	logic single_start_bit;
	logic continuous_start_bit;
	logic [COUNT_WIDTH-1:0] auto_reload_value;
	logic [COUNT_WIDTH-1:0] count;
	run_state_type state;
	logic [6:0] prescale_count;
	logic [1:0] warm_count;
	logic soft_pending;
	logic once_done;
	logic wr_access;
	logic start_write;

	// configuration fields
	logic clock_select_bit;
	logic [1:0] clock_edge_field;
	logic [1:0] input_filter_field;
	logic [1:0] trigger_filter_field;
	logic [2:0] prescaler_field;
	logic [2:0] trigger_select_field;
	logic [1:0] trigger_enable_field;
	logic wave_bit;
	logic external_count_bit;
	logic [2:0] kernel_clock_source_field;
	assign clock_select_bit = cfg[CLK_SEL_POS];
	assign clock_edge_field = cfg[CLK_EDGE_POS +: 2];
	assign input_filter_field = cfg[IN_FILT_POS +: 2];
	assign trigger_filter_field = cfg[TRIG_FILT_POS +: 2];
	assign prescaler_field = cfg[PRESCALE_POS +: 3];
	assign trigger_select_field = cfg[TRIG_SEL_POS +: 3];
	assign trigger_enable_field = cfg[TRIG_EN_POS +: 2];
	assign wave_bit = cfg[WAVE_POS];
	assign external_count_bit = cfg[EXT_COUNT_POS];
	assign kernel_clock_source_field = cfg[SOURCE_POS +: 3];

	// number of equal samples a filter setting asks for
	function automatic logic [3:0] filter_need(input logic [1:0] code);
		filter_need = 4'h1 << code;
	endfunction : filter_need

	// apb: pready rises one edge after setup, so every access has no wait
	assign wr_access = psel & penable & pready & pwrite;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable & ~pready;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				prdata <= 32'h0000_0000;
				if (paddr == CFG_OFFSET) begin
					prdata[CFG_WIDTH-1:0] <= cfg;
				end else if (paddr == CTRL_OFFSET) begin
					prdata[2:0] <= {continuous_start_bit, single_start_bit,
						timer_enable_bit};
				end else if (paddr == RELOAD_OFFSET) begin
					prdata[COUNT_WIDTH-1:0] <= auto_reload_value;
				end else if (paddr == COUNT_OFFSET) begin
					prdata[COUNT_WIDTH-1:0] <= count;
				end else if (paddr == STATUS_OFFSET) begin
					prdata[1:0] <= state;
				end else begin
					pslverr <= 1'b1; // unmapped word
				end
			end
		end
	end

	// configuration and reload writes; software keeps cfg static while on
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg <= CFG_RESET;
			auto_reload_value <= RELOAD_RESET;
		end else if (wr_access) begin
			if (paddr == CFG_OFFSET) begin
				cfg <= pwdata[CFG_WIDTH-1:0];
			end else if (paddr == RELOAD_OFFSET) begin
				auto_reload_value <= pwdata[COUNT_WIDTH-1:0];
			end
		end
	end

	// control bits: start bits only take while enabled, cleared on disable
	assign start_write = wr_access & (paddr == CTRL_OFFSET) & timer_enable_bit
		& (pwdata[SINGLE_POS] | pwdata[CONT_POS]);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_enable_bit <= 1'b0;
			single_start_bit <= 1'b0;
			continuous_start_bit <= 1'b0;
		end else if (wr_access && paddr == CTRL_OFFSET) begin
			timer_enable_bit <= pwdata[ENABLE_POS];
			if (!pwdata[ENABLE_POS]) begin
				single_start_bit <= 1'b0;
				continuous_start_bit <= 1'b0;
			end else if (start_write) begin
				// newest write picks the mode; applied at reload match
				single_start_bit <= pwdata[SINGLE_POS] & ~pwdata[CONT_POS];
				continuous_start_bit <= pwdata[CONT_POS];
			end
		end
	end

	// internal count tick from the selected source
	logic int_tick;
	always_comb begin
		case (kernel_clock_source_field)
			3'h1: int_tick = lsi_tick;
			3'h2: int_tick = lse_tick;
			3'h3: int_tick = hsi_tick;
			3'h4: int_tick = hse_tick;
			3'h5: int_tick = comparator_tick;
			default: int_tick = 1'b1; // bus clock
		endcase
	end

	// sampling rate of filters: sys_clk when input one is the clock,
	// otherwise the internal tick, which filters cannot run without
	logic sample_en;
	assign sample_en = clock_select_bit | int_tick;

	// input 0 is external input one, 1..6 are the hardware triggers
	logic [6:0] raw_in;
	logic [6:0] sync_a;
	logic [6:0] sync_b;
	logic [6:0] filt;
	logic [6:0] filt_prev;
	logic [6:0] rise;
	logic [6:0] fall;
	assign raw_in = {comparator_out, tamper_event_two, tamper_event_one,
		alarm_b, alarm_a, trigger_pin, external_input_one};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : gen_input
			logic [3:0] same_count;
			logic [3:0] need;
			assign need = filter_need(gi == 0 ? input_filter_field
				: trigger_filter_field);
			// two-stage synchroniser, first stage read only by the second
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else if (sample_en) begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
			// glitch filter: new level after need equal samples
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					filt[gi] <= 1'b0;
					filt_prev[gi] <= 1'b0;
					same_count <= 4'h0;
				end else if (sample_en) begin
					filt_prev[gi] <= filt[gi];
					if (sync_b[gi] == filt[gi]) begin
						same_count <= 4'h0;
					end else if (same_count + 4'h1 >= need) begin
						filt[gi] <= sync_b[gi];
						same_count <= 4'h0;
					end else begin
						same_count <= same_count + 4'h1;
					end
				end
			end
			assign rise[gi] = filt[gi] & ~filt_prev[gi] & sample_en;
			assign fall[gi] = ~filt[gi] & filt_prev[gi] & sample_en;
		end
	endgenerate

	// clock edge of input one: both edges only with an internal clock
	logic ext_edge;
	always_comb begin
		if (clock_edge_field == EDGE_RISE) begin
			ext_edge = rise[0];
		end else if (clock_edge_field == EDGE_FALL || clock_select_bit) begin
			ext_edge = fall[0];
		end else begin
			ext_edge = rise[0] | fall[0];
		end
	end

	// kernel tick ahead of the prescaler
	logic kernel_tick;
	always_comb begin
		if (clock_select_bit) begin
			kernel_tick = ext_edge;
		end else if (external_count_bit) begin
			kernel_tick = ext_edge;
		end else begin
			kernel_tick = int_tick;
		end
	end

	// power-of-two prescaler: one count tick every 2^field kernel ticks
	logic count_tick;
	logic [6:0] prescale_mask;
	assign prescale_mask = 7'(8'h01 << prescaler_field) - 7'h01;
	assign count_tick = kernel_tick
		& ((prescale_count & prescale_mask) == prescale_mask);
	always_ff @(posedge sys_clk) begin
		if (rst || !timer_enable_bit) begin
			prescale_count <= 7'h00;
		end else if (kernel_tick) begin
			prescale_count <= prescale_count + 7'h01;
		end
	end

	// trigger multiplexer and active edge
	logic trig_rise;
	logic trig_fall;
	logic trig_edge;
	always_comb begin
		case (trigger_select_field)
			3'h0: {trig_rise, trig_fall} = {rise[1], fall[1]};
			3'h1: {trig_rise, trig_fall} = {rise[2], fall[2]};
			3'h2: {trig_rise, trig_fall} = {rise[3], fall[3]};
			3'h3: {trig_rise, trig_fall} = {rise[4], fall[4]};
			3'h4: {trig_rise, trig_fall} = {rise[5], fall[5]};
			3'h6: {trig_rise, trig_fall} = {rise[6], fall[6]};
			default: {trig_rise, trig_fall} = 2'b00;
		endcase
		case (trigger_enable_field)
			TRIG_RISE: trig_edge = trig_rise;
			TRIG_FALL: trig_edge = trig_fall;
			TRIG_SOFT: trig_edge = 1'b0;
			default: trig_edge = trig_rise | trig_fall;
		endcase
	end

	// start request: software writes, or a hardware edge once armed
	logic mode_armed;
	logic start_req;
	assign mode_armed = single_start_bit | continuous_start_bit;
	always_comb begin
		if (trigger_enable_field == TRIG_SOFT) begin
			start_req = soft_pending;
		end else begin
			start_req = trig_edge & mode_armed
				& ~(wave_bit & once_done);
		end
	end

	// a software start write is held until the kernel can act on it
	always_ff @(posedge sys_clk) begin
		if (rst || !timer_enable_bit) begin
			soft_pending <= 1'b0;
		end else if (start_write && trigger_enable_field == TRIG_SOFT) begin
			soft_pending <= 1'b1; // set wins over the consume below
		end else if (state == ST_STOPPED || state == ST_RUNNING) begin
			soft_pending <= 1'b0; // running ignores it
		end
	end

	// run state and counter
	always_ff @(posedge sys_clk) begin
		if (rst || !timer_enable_bit) begin
			state <= rst ? ST_OFF : (timer_enable_bit ? state : ST_OFF);
			warm_count <= 2'h0;
			count <= '0;
			once_done <= 1'b0;
		end else begin
			case (state)
				ST_OFF: begin
					state <= ST_WARMUP;
				end
				ST_WARMUP: begin
					if (count_tick) begin
						warm_count <= warm_count + 2'h1;
						if (warm_count + 2'h1 == ENABLE_DELAY) begin
							state <= ST_STOPPED;
						end
					end
				end
				ST_STOPPED: begin
					count <= '0;
					if (start_req) begin
						state <= ST_RUNNING;
						once_done <= 1'b1;
					end
				end
				ST_RUNNING: begin
					// triggers are not looked at here
					if (count_tick) begin
						if (count == auto_reload_value) begin
							count <= '0;
							if (!continuous_start_bit) begin
								state <= ST_STOPPED;
							end
						end else begin
							count <= count + 1'b1;
						end
					end
				end
				default: state <= ST_OFF;
			endcase
		end
	end

	// registered status pins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			counter_running <= 1'b0;
			count_value <= '0;
		end else begin
			counter_running <= (state == ST_RUNNING);
			count_value <= count;
		end
	end

	// checks, all on sys_clk and quiet while reset is held
	default clocking check_clk @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence enable_write_s;
		wr_access && paddr == CTRL_OFFSET && pwdata[ENABLE_POS]
			&& !timer_enable_bit;
	endsequence
	sequence one_shot_end_s;
		state == ST_RUNNING && count_tick && count == auto_reload_value
			&& !continuous_start_bit;
	endsequence

	warmup_wait_a: assert property (
		state == ST_WARMUP && !(count_tick && warm_count == ENABLE_DELAY - 2'h1)
		|=> state != ST_STOPPED
	) else $error("kernel turned on before two count ticks");
	start_discard_a: assert property (
		wr_access && paddr == CTRL_OFFSET && !timer_enable_bit
		|=> !single_start_bit && !continuous_start_bit
	) else $error("start bit accepted while disabled");
	enable_off_a: assert property (
		enable_write_s |=> state == ST_OFF ##1 state == ST_WARMUP
	) else $error("enable sequence did not begin");
	one_shot_stop_a: assert property (
		one_shot_end_s and timer_enable_bit
		|=> state == ST_STOPPED && count == '0
	) else $error("one-shot count did not stop at reload");
	count_zero_a: assert property (
		state != ST_RUNNING |-> count == '0
	) else $error("counter not zero while stopped");
	continuous_run_a: assert property (
		state == ST_RUNNING && continuous_start_bit && timer_enable_bit
		|=> state == ST_RUNNING
	) else $error("continuous count stopped");
	count_step_a: assert property (
		state == ST_RUNNING && count_tick && count != auto_reload_value
		&& timer_enable_bit |=> count == $past(count) + 1'b1
	) else $error("counter did not step by one");
	set_once_a: assert property (
		state == ST_STOPPED && wave_bit && once_done && timer_enable_bit
		&& trigger_enable_field != TRIG_SOFT |=> state == ST_STOPPED
	) else $error("set-once restarted on a later trigger");
	run_stays_a: assert property (
		state == ST_RUNNING && !count_tick && timer_enable_bit
		|=> state == ST_RUNNING && count == $past(count)
	) else $error("trigger disturbed a running count");
	// divide by two never gives count ticks on two cycles in a row
	prescale_div_a: assert property (
		count_tick && prescaler_field == 3'h1 |=> !count_tick
	) else $error("divide-by-two ticks on back-to-back cycles");
endmodule : low_power_timer

/* File: trigger_stub.sv */
// far-side stand-in: oscillator ticks, counted input and trigger levels
// assumes the bench pulses fire for one cycle with sel and width held
`timescale 1ns/100ps
module trigger_stub (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic fire,
	input wire logic [2:0] sel,
	input wire logic [7:0] width,
	output logic [5:0] ticks,
	output logic [6:0] trig
);
	logic [7:0] left;
	logic [7:0] phase;
	// pulse length counter; a line drops back to its idle low level after
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			left <= 8'h00;
		end else if (fire) begin
			left <= width;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end
	// free phase for the oscillator strobes
	always_ff @(posedge sys_clk) begin
		phase <= rst ? 8'h00 : phase + 8'h01;
	end
	// index follows the select code; index 5 reaches no timer input and code 7 sets no line
	always_comb begin
		trig = 7'h00;
		trig[sel] = (left != 8'h00);
	end
	// fast strobe runs 8x the counted input, enough for two-edge use
	assign ticks[0] = &phase[2:0];
	assign ticks[1] = &phase[1:0];
	assign ticks[2] = phase[0];
	assign ticks[3] = &phase[3:0];
	assign ticks[4] = &phase[4:0];
	assign ticks[5] = phase[3];
endmodule : trigger_stub

/* File: test_low_power_timer.sv */
// self-checking bench for the low-power timer
// assumes the stub drives ticks and trigger levels from the far side
`timescale 1ns/100ps
module test_low_power_timer
	import low_power_timer_pkg::*;
;
	typedef struct {string what; logic [32:0] lo; logic [32:0] hi;
		logic [15:0] top;} note_type;
	// tick period of each extra clock choice, from the stub's strobe rates
	int tick_period[7] = '{8, 4, 2, 16, 32, 16, 8};
	logic [31:0] src_cfg[7] = '{32'h0002_0000, 32'h0004_0000,
		32'h0006_0000, 32'h0008_0000, 32'h000A_0000, 32'h0000_0001,
		32'h0001_0004};
	logic [15:0] peak = 16'h0000;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fire = 1'b0;
	logic [2:0] sel = 3'h7;
	logic [7:0] width = 8'h08;
	logic [5:0] ticks;
	logic [6:0] trig;
	logic counter_running;
	logic [15:0] count_value;
	logic [31:0] rd;
	logic noted = 1'b0;
	logic was_running = 1'b0;
	note_type read_q[$];
	note_type run_q[$];
	note_type mon_note;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int run_start = 0;

	always #10 sys_clk = ~sys_clk;

	low_power_timer uut (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lsi_tick(ticks[0]),
		.lse_tick(ticks[1]), .hsi_tick(ticks[2]), .hse_tick(ticks[3]),
		.comparator_tick(ticks[4]), .external_input_one(ticks[5]),
		.trigger_pin(trig[0]), .alarm_a(trig[1]), .alarm_b(trig[2]),
		.tamper_event_one(trig[3]), .tamper_event_two(trig[4]),
		.comparator_out(trig[6]), .counter_running(counter_running),
		.count_value(count_value)
	);

	trigger_stub partner (
		.sys_clk(sys_clk), .rst(rst), .fire(fire), .sel(sel),
		.width(width), .ticks(ticks), .trig(trig)
	);

	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [32:0] seen,
		input logic [32:0] lo, input logic [32:0] hi);
		checks_done++;
		if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, seen);
		end
	endtask : check

	// one apb transfer; request held until pready is seen high at an edge
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd_chk(input string what, input logic [11:0] a,
		input logic [32:0] v);
		read_q.push_back('{what, v, v, 16'h0000});
		noted = 1'b1;
		xfer(1'b0, a, 32'h0000_0000);
		noted = 1'b0;
	endtask : rd_chk

	task automatic poll(input logic [1:0] v);
		do begin
			xfer(1'b0, STATUS_OFFSET, 32'h0000_0000);
		end while (rd[1:0] !== v);
	endtask : poll

	// configuration only changes with the timer off
	task automatic setup(input logic [31:0] cfg, input logic [31:0] top);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0000);
		xfer(1'b1, CFG_OFFSET, cfg);
		xfer(1'b1, RELOAD_OFFSET, top);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0001);
		poll(2'h2);
	endtask : setup

	task automatic pulse(input logic [2:0] s, input logic [7:0] w);
		@(posedge sys_clk);
		sel <= s;
		width <= w;
		fire <= 1'b1;
		@(posedge sys_clk);
		fire <= 1'b0;
	endtask : pulse

	// hardware start, retrigger while running, then a trigger after stop
	task automatic hw_case(input logic [2:0] s, input logic [1:0] e,
		input logic once);
		setup((32'(e) << TRIG_EN_POS) | (32'(s) << TRIG_SEL_POS) |
			(32'(once) << WAVE_POS), 32'h0000_0018);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0003);
		pulse(s ^ 3'h1, 8'h08);
		repeat (14) @(posedge sys_clk);
		rd_chk("armed", STATUS_OFFSET, 33'h0_0000_0002);
		run_q.push_back('{"hw run", 33'h0_0000_0018,
			33'h0_0000_001C, 16'h0018});
		pulse(s, 8'h08);
		repeat (12) @(posedge sys_clk);
		pulse(s, 8'h08);
		poll(2'h2);
		pulse(s, 8'h08);
		repeat (14) @(posedge sys_clk);
		rd_chk("again", STATUS_OFFSET, once ? 33'h2 : 33'h3);
	endtask : hw_case

	// reads and run lengths are judged against the oldest note
	always @(negedge sys_clk) begin
		if (noted && psel && penable && pready === 1'b1 && !pwrite) begin
			mon_note = read_q.pop_front();
			check(mon_note.what, {pslverr, prdata},
				mon_note.lo, mon_note.hi);
		end
		if (counter_running === 1'b1 && !was_running) begin
			run_start = cycles;
			peak = 16'h0000;
		end
		if (counter_running === 1'b1 && count_value > peak) begin
			peak = count_value;
		end
		if (counter_running !== 1'b1 && was_running && run_q.size() > 0) begin
			mon_note = run_q.pop_front();
			check(mon_note.what, 33'(cycles - run_start),
				mon_note.lo, mon_note.hi);
			check({mon_note.what, " top"}, 33'(peak),
				33'(mon_note.top), 33'(mon_note.top));
			check({mon_note.what, " zero"}, 33'(count_value),
				33'h0_0000_0000, 33'h0_0000_0000);
		end
		was_running = (counter_running === 1'b1);
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			close_out();
		end
	end

	initial begin
		logic [31:0] r;
		int d;
		void'($urandom(32'hd6fb70e1));
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk("cfg", CFG_OFFSET, 33'h0_0000_0000);
		rd_chk("reload", RELOAD_OFFSET, 33'h0_0000_FFFF);
		xfer(1'b1, 12'h040, $urandom());
		rd_chk("unmapped", 12'h040, 33'h1_0000_0000);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0006);
		setup(32'h0000_0000, 32'h0000_0005);
		repeat (20) @(posedge sys_clk);
		rd_chk("no start", STATUS_OFFSET, 33'h0_0000_0002);
		// every prescaler code with a random short reload
		for (int p = 0; p < 8; p++) begin
			r = 32'h0000_0002 + ($urandom() % 32'h0000_0008);
			d = 1 << p;
			setup(32'(p) << PRESCALE_POS, r);
			run_q.push_back('{"run", 33'(r * d),
				33'((r + 2) * d + 2), r[15:0]});
			xfer(1'b1, CTRL_OFFSET, 32'h0000_0003);
			poll(2'h2);
			rd_chk("count", COUNT_OFFSET, 33'h0_0000_0000);
		end
		// each internal source, input one as clock, input one counted
		for (int k = 0; k < 7; k++) begin
			r = 32'h0000_0002 + ($urandom() % 32'h0000_0008);
			setup(src_cfg[k], r);
			run_q.push_back('{"source", 33'(r * tick_period[k]),
				33'((r + 2) * tick_period[k] + 2), r[15:0]});
			xfer(1'b1, CTRL_OFFSET, 32'h0000_0003);
			poll(2'h2);
		end
		// continuous start, switch to one-shot, and back
		setup(32'h0000_0000, 32'h0000_0014);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0005);
		repeat (50) @(posedge sys_clk);
		rd_chk("cont", STATUS_OFFSET, 33'h0_0000_0003);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0003);
		repeat (30) @(posedge sys_clk);
		rd_chk("to single", STATUS_OFFSET, 33'h0_0000_0002);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0003);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0005);
		repeat (60) @(posedge sys_clk);
		rd_chk("to cont", STATUS_OFFSET, 33'h0_0000_0003);
		// every trigger input and active edge, then set-once
		for (int i = 0; i < 6; i++) begin
			hw_case((i == 5) ? 3'h6 : 3'(i), 2'(1 + i % 3), 1'b0);
		end
		hw_case(3'h2, 2'h1, 1'b1);
		// bus clock stays in use while the filter is on
		setup((32'h0000_0003 << TRIG_FILT_POS) |
			(32'h0000_0001 << TRIG_EN_POS), 32'h0000_0018);
		xfer(1'b1, CTRL_OFFSET, 32'h0000_0003);
		pulse(3'h0, 8'h03);
		repeat (20) @(posedge sys_clk);
		rd_chk("glitch", STATUS_OFFSET, 33'h0_0000_0002);
		pulse(3'h0, 8'h10);
		repeat (20) @(posedge sys_clk);
		rd_chk("steady", STATUS_OFFSET, 33'h0_0000_0003);
		close_out();
	end
endmodule : test_low_power_timer
